// File: rtl/vfp_exc_pkg.sv
// Constants for the vector floating-point exception unit: fields, offsets, codes.
// Assumes one core clock and an APB register port with 32-bit data.
//
// What this block does
// - With flushing on, subnormal operands and tiny results become signed zero.
// - Flushed tiny results, caught before rounding, raise inexact and underflow except reciprocals.
// - Flushed subnormal operands raise inexact, except in comparisons.
// - Non-trapping bit: 0 means trapping mode, 1 means non-trapping mode.
// - Trapping mode: enabled exception leaves destination unwritten, sets cause, traps.
// - Non-trapping: faulting elements get signaling NaN with low six exception bits.
// - Non-trapping mode takes no floating-point exception, even unimplemented operation.
// - Enable bits still pick default results; disabled conditions give default values.
// - Unimplemented operation is always enabled: enable mask ORs in its bit.
// - Exception bits: E 0x20, V bit 4, Z bit 3, O 0x04, U 0x02, I 0x01.
// - Overflow without overflow enabled also sets inexact for that element.
// - Exact underflow with underflow disabled clears the underflow bit.
// - No enabled exception: OR bits into cause; result if clean, else default.
// - Flags update after all elements only when cause holds no enabled exception.
// - Trapping mode signals the exception when any element hits an enabled condition.
// - Cause, enable, flags hold one bit per condition; cause adds unimplemented bit.
// - Reserved-instruction code 0x0A when vector absent or usable unit in 32-bit mode.
// - Privileged control moves without system access: code 0x0B, coprocessor field 0.
// - Vector-disabled code 0x15 when disabled or partitioned register unavailable.
// - Data-dependent faults raise code 0x0E with reason in cause bits.
// - Control/status: enables 11:7, cause 17:12, flags 6:2.

`default_nettype none

package vfp_exc_pkg;

	// ----------------------------------------
	// Exception bit positions and masks
	// ----------------------------------------
	localparam int           BIT_E  = 5;
	localparam int           BIT_V  = 4;
	localparam int           BIT_Z  = 3;
	localparam int           BIT_O  = 2;
	localparam int           BIT_U  = 1;
	localparam int           BIT_I  = 0;
	localparam logic [5:0]   MASK_E = 6'h20;
	localparam logic [5:0]   MASK_O = 6'h04;
	localparam logic [5:0]   MASK_U = 6'h02;
	localparam logic [5:0]   MASK_I = 6'h01;
	localparam int           NAN_LO = 6;

	// ----------------------------------------
	// Control/status register layout
	// ----------------------------------------
	localparam int           RM_LO      = 0;
	localparam int           RM_HI      = 1;
	localparam int           FLAGS_LO   = 2;
	localparam int           FLAGS_HI   = 6;
	localparam int           EN_LO      = 7;
	localparam int           EN_HI      = 11;
	localparam int           CAUSE_LO   = 12;
	localparam int           CAUSE_HI   = 17;
	localparam int           NTRAP_BIT  = 18;
	localparam int           FLUSH_BIT  = 24;
	localparam logic [31:0]  CSR_RST    = 32'h0000_0000;
	localparam logic [31:0]  CSR_WMASK  = 32'h0107_FFFF;

	// ----------------------------------------
	// Core configuration register layout
	// ----------------------------------------
	localparam int           CFG_FR32      = 0;
	localparam int           CFG_PARTITION = 1;
	localparam int           CFG_CP0       = 2;
	localparam int           CFG_VEC_EN    = 27;
	localparam int           CFG_PRESENT   = 28;
	localparam int           CFG_FPU_USE   = 29;
	localparam logic [31:0]  CFG_RST       = 32'h0000_0000;
	localparam logic [31:0]  CFG_WMASK     = 32'h3800_0007;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0]  OFS_CSR = 12'h000;
	localparam logic [11:0]  OFS_CFG = 12'h004;
	localparam logic [11:0]  OFS_EXC = 12'h008;

	// ----------------------------------------
	// Core exception codes
	// ----------------------------------------
	typedef enum logic [4:0]
	{
		EXC_NONE = 5'h00,
		EXC_RSV  = 5'h0A,
		EXC_CPU  = 5'h0B,
		EXC_FPE  = 5'h0E,
		EXC_DIS  = 5'h15
	} exc_code_t;

endpackage

`default_nettype wire

// File: rtl/vfp_elem_exc.sv
// Per-element exception shaping and destination value selection.
// Assumes same-cycle inputs from the datapath; purely combinational.

`default_nettype none

module vfp_elem_exc #(
	parameter int ELEM_W = 32
) (
	// Mode
	input  wire logic              flush_i,
	input  wire logic              nontrap_i,
	input  wire logic              recip_i,
	input  wire logic              compare_i,
	input  wire logic [4:0]        enable_i,
	// Element conditions and values
	input  wire logic [5:0]        exc_i,
	input  wire logic              tiny_i,
	input  wire logic              sub_in_i,
	input  wire logic [ELEM_W-1:0] result_i,
	input  wire logic [ELEM_W-1:0] default_i,
	input  wire logic [ELEM_W-1:0] snan_i,
	// Outcome
	output logic [5:0]             exc_o,
	output logic [5:0]             contrib_o,
	output logic                   hit_o,
	output logic [ELEM_W-1:0]      value_o
);

	logic [5:0]        enable;
	logic [5:0]        c_flush;
	logic [5:0]        c_ovf;
	logic              tiny_flush;
	logic [ELEM_W-1:0] zero_res;

	// ----------------------------------------
	// Condition shaping
	// ----------------------------------------
	assign enable     = vfp_exc_pkg::MASK_E | {1'b0, enable_i};
	assign tiny_flush = flush_i & tiny_i;
	assign c_flush    = exc_i
	                  | ((tiny_flush && !recip_i) ? (vfp_exc_pkg::MASK_U | vfp_exc_pkg::MASK_I) : 6'h00)
	                  | ((flush_i && sub_in_i && !compare_i) ? vfp_exc_pkg::MASK_I : 6'h00);
	assign c_ovf      = (c_flush[vfp_exc_pkg::BIT_O] && !enable[vfp_exc_pkg::BIT_O])
	                  ? (c_flush | vfp_exc_pkg::MASK_I) : c_flush;
	assign exc_o      = (c_ovf[vfp_exc_pkg::BIT_U] && !enable[vfp_exc_pkg::BIT_U] && !c_ovf[vfp_exc_pkg::BIT_I])
	                  ? (c_ovf & ~vfp_exc_pkg::MASK_U) : c_ovf;

	// ----------------------------------------
	// Enabled hit, cause share, value
	// ----------------------------------------
	assign hit_o     = |(exc_o & enable);
	assign contrib_o = (hit_o && nontrap_i) ? 6'h00 : exc_o;
	assign zero_res  = {result_i[ELEM_W-1], {(ELEM_W-1){1'b0}}};
	assign value_o   = hit_o ? {snan_i[ELEM_W-1:vfp_exc_pkg::NAN_LO], exc_o}
	                 : tiny_flush ? zero_res
	                 : (exc_o == 6'h00) ? result_i : default_i;

endmodule

`default_nettype wire

// File: rtl/vfp_exc_unit.sv
// Vector floating-point exception unit: control/status, access checks, per-element merge.
// Assumes an APB master on the core clock and a datapath giving one op per op_valid_i pulse.

`default_nettype none

module vfp_exc_unit #(
	parameter int N_ELEM = 4,
	parameter int ELEM_W = 32
) (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     nrst_i,
	// APB slave
	input  wire logic [11:0]              paddr_i,
	input  wire logic                     psel_i,
	input  wire logic                     penable_i,
	input  wire logic                     pwrite_i,
	input  wire logic [31:0]              pwdata_i,
	input  wire logic [3:0]               pstrb_i,
	output logic [31:0]                   prdata_o,
	output logic                          pready_o,
	output logic                          pslverr_o,
	// Mode to datapath
	output logic [1:0]                    round_mode_o,
	output logic                          flush_o,
	// Operand flushing
	input  wire logic                     opnd_valid_i,
	input  wire logic [N_ELEM*ELEM_W-1:0] opnd_i,
	input  wire logic [N_ELEM-1:0]        opnd_sub_i,
	output logic                          opnd_valid_o,
	output logic [N_ELEM*ELEM_W-1:0]      opnd_o,
	// Instruction
	input  wire logic                     op_valid_i,
	input  wire logic                     op_fp_i,
	input  wire logic                     op_compare_i,
	input  wire logic                     op_recip_i,
	input  wire logic                     op_ctl_move_i,
	input  wire logic                     op_priv_ctl_i,
	input  wire logic                     op_reg_unavail_i,
	// Element conditions
	input  wire logic [N_ELEM*6-1:0]      elem_exc_i,
	input  wire logic [N_ELEM-1:0]        elem_tiny_i,
	input  wire logic [N_ELEM-1:0]        elem_sub_in_i,
	input  wire logic [N_ELEM*ELEM_W-1:0] elem_result_i,
	input  wire logic [N_ELEM*ELEM_W-1:0] elem_default_i,
	input  wire logic [N_ELEM*ELEM_W-1:0] elem_snan_i,
	// Completion
	output logic                          done_o,
	output logic                          dest_we_o,
	output logic [N_ELEM*ELEM_W-1:0]      dest_o,
	output logic                          exc_valid_o,
	output logic [4:0]                    exc_code_o,
	output logic [1:0]                    exc_ce_o
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	logic [31:0]               csr;
	logic [31:0]               cfg;
	logic [4:0]                last_code;
	logic [31:0]               next_csr;
	logic [31:0]               next_cfg;
	logic [31:0]               byte_mask;
	logic [31:0]               rd_word;
	logic [31:0]               csr_base;
	wire                       sel_csr = (paddr_i == vfp_exc_pkg::OFS_CSR);
	wire                       sel_cfg = (paddr_i == vfp_exc_pkg::OFS_CFG);
	wire                       sel_exc = (paddr_i == vfp_exc_pkg::OFS_EXC);
	wire                       mapped  = sel_csr | sel_cfg | sel_exc;
	wire                       acc     = psel_i & penable_i;
	wire                       wr_csr  = acc & pwrite_i & sel_csr;
	wire                       wr_cfg  = acc & pwrite_i & sel_cfg;
	wire                       nontrap = csr[vfp_exc_pkg::NTRAP_BIT];
	wire                       flush   = csr[vfp_exc_pkg::FLUSH_BIT];
	wire [4:0]                 enables = csr[vfp_exc_pkg::EN_HI:vfp_exc_pkg::EN_LO];
	wire [5:0]                 cause   = csr[vfp_exc_pkg::CAUSE_HI:vfp_exc_pkg::CAUSE_LO];
	wire [4:0]                 flags   = csr[vfp_exc_pkg::FLAGS_HI:vfp_exc_pkg::FLAGS_LO];

	assign byte_mask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
	assign rd_word   = sel_csr ? csr
	                 : sel_cfg ? cfg
	                 : sel_exc ? {27'h0, last_code}
	                 : 32'h0000_0000;
	assign pready_o     = 1'b1;
	assign pslverr_o    = acc & ~mapped;
	assign round_mode_o = csr[vfp_exc_pkg::RM_HI:vfp_exc_pkg::RM_LO];
	assign flush_o      = flush;

	// ----------------------------------------
	// Access checks
	// ----------------------------------------
	wire rsv_hit = ~cfg[vfp_exc_pkg::CFG_PRESENT]
	             | (cfg[vfp_exc_pkg::CFG_FPU_USE] & cfg[vfp_exc_pkg::CFG_FR32]);
	wire cpu_hit = op_ctl_move_i & op_priv_ctl_i & ~cfg[vfp_exc_pkg::CFG_CP0];
	wire dis_hit = ~cfg[vfp_exc_pkg::CFG_VEC_EN]
	             | (cfg[vfp_exc_pkg::CFG_PARTITION] & op_reg_unavail_i);
	wire acc_exc = rsv_hit | cpu_hit | dis_hit;
	wire commit  = op_valid_i & op_fp_i & ~acc_exc;

	// ----------------------------------------
	// Element lanes
	// ----------------------------------------
	logic [N_ELEM*6-1:0]      lane_exc;
	logic [N_ELEM*6-1:0]      lane_contrib;
	logic [N_ELEM-1:0]        lane_hit;
	logic [N_ELEM*ELEM_W-1:0] lane_value;
	logic [N_ELEM*ELEM_W-1:0] opnd_flushed;
	logic [5:0]               new_cause;

	genvar g;
	generate
		for (g = 0; g < N_ELEM; g++)
		begin : lane
			vfp_elem_exc #(.ELEM_W(ELEM_W)) u_elem (
				.flush_i   (flush),
				.nontrap_i (nontrap),
				.recip_i   (op_recip_i),
				.compare_i (op_compare_i),
				.enable_i  (enables),
				.exc_i     (elem_exc_i[g*6 +: 6]),
				.tiny_i    (elem_tiny_i[g]),
				.sub_in_i  (elem_sub_in_i[g]),
				.result_i  (elem_result_i[g*ELEM_W +: ELEM_W]),
				.default_i (elem_default_i[g*ELEM_W +: ELEM_W]),
				.snan_i    (elem_snan_i[g*ELEM_W +: ELEM_W]),
				.exc_o     (lane_exc[g*6 +: 6]),
				.contrib_o (lane_contrib[g*6 +: 6]),
				.hit_o     (lane_hit[g]),
				.value_o   (lane_value[g*ELEM_W +: ELEM_W])
			);
			assign opnd_flushed[g*ELEM_W +: ELEM_W] = (flush && opnd_sub_i[g])
			        ? {opnd_i[(g+1)*ELEM_W-1], {(ELEM_W-1){1'b0}}}
			        : opnd_i[g*ELEM_W +: ELEM_W];
		end
	endgenerate

	always_comb
	begin
		new_cause = 6'h00;
		for (int k = 0; k < N_ELEM; k++)
		begin
			new_cause = new_cause | lane_contrib[k*6 +: 6];
		end
	end

	wire any_hit = |lane_hit;
	wire trap    = commit & any_hit & ~nontrap;

	// ----------------------------------------
	// Control/status next value
	// ----------------------------------------
	always_comb
	begin
		csr_base = wr_csr ? (((csr & ~byte_mask) | (pwdata_i & byte_mask)) & vfp_exc_pkg::CSR_WMASK) : csr;
		next_csr = csr_base;
		if (commit)
		begin
			next_csr[vfp_exc_pkg::CAUSE_HI:vfp_exc_pkg::CAUSE_LO] = new_cause;
			if (!trap)
			begin
				next_csr[vfp_exc_pkg::FLAGS_HI:vfp_exc_pkg::FLAGS_LO] =
					csr_base[vfp_exc_pkg::FLAGS_HI:vfp_exc_pkg::FLAGS_LO] | new_cause[4:0];
			end
		end
		next_cfg = wr_cfg ? (((cfg & ~byte_mask) | (pwdata_i & byte_mask)) & vfp_exc_pkg::CFG_WMASK) : cfg;
	end

	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			csr      <= vfp_exc_pkg::CSR_RST;
			cfg      <= vfp_exc_pkg::CFG_RST;
			prdata_o <= 32'h0000_0000;
		end
		else
		begin
			csr <= next_csr;
			cfg <= next_cfg;
			if (psel_i && !penable_i)
			begin
				prdata_o <= rd_word;
			end
		end
	end

	// ----------------------------------------
	// Completion outputs
	// ----------------------------------------
	logic [4:0] next_code;

	always_comb
	begin
		next_code = vfp_exc_pkg::EXC_NONE;
		if (rsv_hit)
		begin
			next_code = vfp_exc_pkg::EXC_RSV;
		end
		else if (cpu_hit)
		begin
			next_code = vfp_exc_pkg::EXC_CPU;
		end
		else if (dis_hit)
		begin
			next_code = vfp_exc_pkg::EXC_DIS;
		end
		else if (trap)
		begin
			next_code = vfp_exc_pkg::EXC_FPE;
		end
	end

	wire next_exc = op_valid_i & (acc_exc | trap);

	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done_o       <= 1'b0;
			dest_we_o    <= 1'b0;
			dest_o       <= '0;
			exc_valid_o  <= 1'b0;
			exc_code_o   <= 5'h00;
			exc_ce_o     <= 2'h0;
			last_code    <= 5'h00;
			opnd_valid_o <= 1'b0;
			opnd_o       <= '0;
		end
		else
		begin
			done_o       <= op_valid_i;
			dest_we_o    <= commit & ~trap;
			exc_valid_o  <= next_exc;
			exc_code_o   <= next_exc ? next_code : 5'h00;
			exc_ce_o     <= 2'h0;
			opnd_valid_o <= opnd_valid_i;
			if (commit)
			begin
				dest_o <= lane_value;
			end
			if (next_exc)
			begin
				last_code <= next_code;
			end
			if (opnd_valid_i)
			begin
				opnd_o <= opnd_flushed;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	property p_fpe_trap;
		commit && any_hit && !nontrap |=> exc_valid_o && exc_code_o == 5'h0E && !dest_we_o;
	endproperty
	a_fpe_trap: assert property (p_fpe_trap) else $error("enabled hit did not trap with code 0x0E");

	property p_trap_no_write;
		exc_valid_o |-> !dest_we_o;
	endproperty
	a_trap_no_write: assert property (p_trap_no_write) else $error("destination written on exception");

	property p_nontrap_no_trap;
		op_valid_i && !acc_exc && nontrap |=> !exc_valid_o;
	endproperty
	a_nontrap_no_trap: assert property (p_nontrap_no_trap) else $error("exception taken in non-trapping mode");

	property p_rsv_code;
		op_valid_i && !cfg[vfp_exc_pkg::CFG_PRESENT] |=> exc_valid_o && exc_code_o == 5'h0A;
	endproperty
	a_rsv_code: assert property (p_rsv_code) else $error("absent vector unit did not give code 0x0A");

	property p_cpu_code;
		op_valid_i && !rsv_hit && op_ctl_move_i && op_priv_ctl_i && !cfg[vfp_exc_pkg::CFG_CP0]
		|=> exc_valid_o && exc_code_o == 5'h0B && exc_ce_o == 2'h0;
	endproperty
	a_cpu_code: assert property (p_cpu_code) else $error("privileged move did not give code 0x0B");

	property p_dis_code;
		op_valid_i && !rsv_hit && !cpu_hit && !cfg[vfp_exc_pkg::CFG_VEC_EN]
		|=> exc_valid_o && exc_code_o == 5'h15;
	endproperty
	a_dis_code: assert property (p_dis_code) else $error("disabled vector unit did not give code 0x15");

	property p_flags_hold;
		trap && !wr_csr |=> flags == $past(flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed on a trapping instruction");

	property p_cause_clean;
		commit && elem_exc_i == '0 && elem_tiny_i == '0 && elem_sub_in_i == '0 |=> cause == 6'h00 && !exc_valid_o;
	endproperty
	a_cause_clean: assert property (p_cause_clean) else $error("cause not cleared by a clean instruction");

	property p_opnd_flush;
		opnd_valid_i && flush && opnd_sub_i[0]
		|=> opnd_o[ELEM_W-2:0] == '0 && opnd_o[ELEM_W-1] == $past(opnd_i[ELEM_W-1]);
	endproperty
	a_opnd_flush: assert property (p_opnd_flush) else $error("subnormal operand not flushed to signed zero");

	property p_ovf_inexact;
		lane_exc[vfp_exc_pkg::BIT_O] && !enables[vfp_exc_pkg::BIT_O] |-> lane_exc[vfp_exc_pkg::BIT_I];
	endproperty
	a_ovf_inexact: assert property (p_ovf_inexact) else $error("disabled overflow lacks inexact");

endmodule

`default_nettype wire

// File: bench/vfp_datapath_model.sv
// Model of the vector datapath that presents one instruction and its element conditions.
// Assumes the unit samples op_valid_o on a rising clock_i edge and answers one cycle later.

`default_nettype none

module vfp_datapath_model #(
	parameter logic [127:0] RES = 128'h0,
	parameter logic [127:0] DEF = 128'h0,
	parameter logic [127:0] NAN = 128'h0
) (
	// Clock
	input  wire logic         clock_i,
	// Instruction
	output logic              op_valid_o,
	output logic [5:0]        op_kind_o,
	// Element conditions
	output logic [23:0]       elem_exc_o,
	output logic [3:0]        elem_tiny_o,
	output logic [3:0]        elem_sub_in_o,
	output logic [127:0]      elem_result_o,
	output logic [127:0]      elem_default_o,
	output logic [127:0]      elem_snan_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		op_valid_o     = 1'b0;
		op_kind_o      = 6'h00;
		elem_exc_o     = 24'hFFFFFF;
		elem_tiny_o    = 4'hF;
		elem_sub_in_o  = 4'hF;
		elem_result_o  = ~RES;
		elem_default_o = ~DEF;
		elem_snan_o    = ~NAN;
	end

	// ----------------------------------------
	// One-cycle instruction, then inverted data
	// ----------------------------------------
	task automatic issue(input logic [5:0] kind, input logic [23:0] exc, input logic [3:0] tiny, input logic [3:0] sub);
		@(posedge clock_i);
		op_valid_o     <= 1'b1;
		op_kind_o      <= kind;
		elem_exc_o     <= exc;
		elem_tiny_o    <= tiny;
		elem_sub_in_o  <= sub;
		elem_result_o  <= RES;
		elem_default_o <= DEF;
		elem_snan_o    <= NAN;
		@(posedge clock_i);
		op_valid_o     <= 1'b0;
		op_kind_o      <= ~kind;
		elem_exc_o     <= ~exc;
		elem_tiny_o    <= ~tiny;
		elem_sub_in_o  <= ~sub;
		elem_result_o  <= ~RES;
		elem_default_o <= ~DEF;
		elem_snan_o    <= ~NAN;
	endtask

endmodule

`default_nettype wire

// File: bench/vector_fp_exception_unit_tb.sv
// Self-checking bench for the vector floating-point exception unit.
// Assumes the datapath model drives instructions and APB tasks reach the registers.

`default_nettype none

module vector_fp_exception_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [127:0] RES  = {32'h4100_0003, 32'h4000_0002, 32'h3F80_0001, 32'h8000_0009};
	localparam logic [127:0] DEF  = {32'h7FC0_0000, 32'h7F80_0000, 32'hFF80_0000, 32'h7FC0_0001};
	localparam logic [127:0] NAN  = {4{32'h7FAB_CDFF}};
	localparam logic [127:0] OPND = {32'h807F_FFFF, 32'h3F80_0000, 32'h8000_0003, 32'h0000_0005};

	logic          clock_i, nrst_i, psel_i, penable_i, pwrite_i, opnd_valid_i;
	logic [11:0]   paddr_i;
	logic [31:0]   pwdata_i, prdata_o, rd;
	logic [127:0]  opnd_i, opnd_o, dest_o, res_v, def_v, nan_v;
	logic [3:0]    opnd_sub_i, tiny_v, sub_v;
	logic          pready_o, pslverr_o, opnd_valid_o, done_o, dest_we_o, exc_valid_o, op_v, err;
	logic [5:0]    kind_v;
	logic [23:0]   exc_v;
	logic [4:0]    exc_code_o;
	logic [1:0]    round_mode_o, exc_ce_o;
	logic          flush_o;
	int            mismatches, checks;
	logic [31:0]   cfg_tab[5]  = '{32'h0, 32'h3000_0001, 32'h1000_0004, 32'h1800_0002, 32'h1800_0000};
	logic [5:0]    kind_tab[5] = '{6'h01, 6'h01, 6'h01, 6'h21, 6'h19};
	logic [4:0]    code_tab[5] = '{5'h0A, 5'h0A, 5'h15, 5'h15, 5'h0B};

	vfp_datapath_model #(.RES(RES), .DEF(DEF), .NAN(NAN)) i_vfp_datapath_model (.clock_i(clock_i),
		.op_valid_o(op_v), .op_kind_o(kind_v), .elem_exc_o(exc_v), .elem_tiny_o(tiny_v), .elem_sub_in_o(sub_v),
		.elem_result_o(res_v), .elem_default_o(def_v), .elem_snan_o(nan_v));

	vfp_exc_unit i_vfp_exc_unit (.clock_i(clock_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .round_mode_o(round_mode_o), .flush_o(flush_o),
		.opnd_valid_i(opnd_valid_i),
		.opnd_i(opnd_i), .opnd_sub_i(opnd_sub_i), .opnd_valid_o(opnd_valid_o), .opnd_o(opnd_o),
		.op_valid_i(op_v), .op_fp_i(kind_v[0]), .op_compare_i(kind_v[1]), .op_recip_i(kind_v[2]),
		.op_ctl_move_i(kind_v[3]), .op_priv_ctl_i(kind_v[4]), .op_reg_unavail_i(kind_v[5]), .elem_exc_i(exc_v),
		.elem_tiny_i(tiny_v), .elem_sub_in_i(sub_v), .elem_result_i(res_v), .elem_default_i(def_v),
		.elem_snan_i(nan_v), .done_o(done_o), .dest_we_o(dest_we_o), .dest_o(dest_o), .exc_valid_o(exc_valid_o),
		.exc_code_o(exc_code_o), .exc_ce_o(exc_ce_o));

	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic results();
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ----------------------------------------
	// APB transfer: setup, access until pready
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do
			@(posedge clock_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task automatic op(input string nm, input logic [5:0] k, input logic [23:0] e, input logic [3:0] t,
		input logic [3:0] s, input logic [4:0] code, input logic [127:0] dest, input logic [31:0] csr);
		i_vfp_datapath_model.issue(k, e, t, s);
		#1;
		chk({nm, "_done"}, 1'b1, done_o);
		chk({nm, "_we"}, code == 5'h00, dest_we_o);
		chk({nm, "_exc"}, code != 5'h00, exc_valid_o);
		chk({nm, "_code"}, code, exc_code_o);
		chk({nm, "_ce"}, 2'h0, exc_ce_o);
		if (code == 5'h00)
			chk({nm, "_dest"}, dest, dest_o);
		rdc({nm, "_csr"}, vfp_exc_pkg::OFS_CSR, csr);
	endtask

	task automatic opnd(input string nm, input logic [127:0] exp);
		@(posedge clock_i);
		opnd_valid_i <= 1'b1;
		opnd_i       <= OPND;
		opnd_sub_i   <= 4'b1011;
		@(posedge clock_i);
		opnd_valid_i <= 1'b0;
		opnd_i       <= ~OPND;
		opnd_sub_i   <= 4'b0100;
		#1;
		chk({nm, "_valid"}, 1'b1, opnd_valid_o);
		chk(nm, exp, opnd_o);
	endtask

	initial
	begin
		repeat (3000) @(posedge clock_i);
		mismatches++;
		results();
	end

	initial
	begin
		{psel_i, penable_i, pwrite_i, opnd_valid_i, nrst_i} = 5'h00;
		{paddr_i, pwdata_i, opnd_i, opnd_sub_i} = '0;
		repeat (12) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rdc("csr_rst", vfp_exc_pkg::OFS_CSR, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped_err", 1'b1, err);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'hFFFF_FFFF);
		rdc("csr_fields", vfp_exc_pkg::OFS_CSR, 32'h0107_FFFF);
		chk("round_mode", 2'h3, round_mode_o);
		chk("flush_out", 1'b1, flush_o);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, vfp_exc_pkg::OFS_CFG, cfg_tab[i]);
			op("access", kind_tab[i], 24'h0, 4'h0, 4'h0, code_tab[i], 128'h0, 32'h0);
		end
		rdc("last_code", vfp_exc_pkg::OFS_EXC, 32'h0000_000B);
		apb(1'b1, vfp_exc_pkg::OFS_CFG, 32'h1800_0004);
		op("dflt", 6'h01, 24'h0100C4, 4'h0, 4'h0, 5'h00, {RES[127:96], DEF[95:0]}, 32'h0001_705C);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'h0000_025C);
		op("trap", 6'h01, 24'h000004, 4'h0, 4'h0, 5'h0E, 128'h0, 32'h0000_425C);
		op("clean", 6'h01, 24'h0, 4'h0, 4'h0, 5'h00, RES, 32'h0000_025C);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'h0004_025C);
		op("nontrap", 6'h01, 24'h802004, 4'h0, 4'h0, 5'h00, {NAN[127:102], 6'h20, RES[95:32], NAN[31:6], 6'h04},
			32'h0004_025C);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'h0);
		op("unimpl", 6'h01, 24'h000020, 4'h0, 4'h0, 5'h0E, 128'h0, 32'h0002_0000);
		opnd("opnd_pass", OPND);
		apb(1'b1, vfp_exc_pkg::OFS_CSR, 32'h0100_0000);
		opnd("opnd_flush", {32'h8000_0000, OPND[95:64], 32'h8000_0000, 32'h0});
		op("flush", 6'h01, 24'h0, 4'h1, 4'h2, 5'h00, {RES[127:64], DEF[63:32], 32'h8000_0000}, 32'h0100_300C);
		op("recip", 6'h05, 24'h0, 4'h1, 4'h0, 5'h00, {RES[127:32], 32'h8000_0000}, 32'h0100_000C);
		op("cmp", 6'h03, 24'h0, 4'h0, 4'h2, 5'h00, RES, 32'h0100_000C);
		results();
	end

endmodule

`default_nettype wire
